// file: verilog/pmta_pkg.sv
`default_nettype none
package pmta_pkg;

    localparam int PAGE_W     = 8;
    localparam int EA_W       = 16;
    localparam int PADDR_W    = 24;
    localparam int PWORD_W    = 24;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int LANES      = 3;
    localparam int CNT_W      = 8;

    // field positions in the program word
    localparam int LOW_LSB    = 0;
    localparam int LOW_MSB    = 15;
    localparam int HIGH_LSB   = 16;
    localparam int HIGH_MSB   = 23;
    localparam int LANE_HIGH  = 2;

    // self-programming granularity, in instructions, with the row size also given in bytes
    localparam logic [CNT_W-1:0] ROW_INSTR    = 8'h20;
    localparam int               ROW_BYTES    = 96;
    localparam logic [CNT_W-1:0] ERASE_SMALL  = 8'h20;
    localparam logic [CNT_W-1:0] ERASE_MID    = 8'h40;
    localparam logic [CNT_W-1:0] ERASE_LARGE  = 8'h80;
    localparam logic [1:0]       SEL_SMALL    = 2'h0;
    localparam logic [1:0]       SEL_MID      = 2'h1;
    localparam logic [1:0]       SEL_LARGE    = 2'h2;
    localparam logic [1:0]       ADDR_SHIFT   = 2'h1;

    localparam logic [PWORD_W-1:0] WORD_RST   = 24'h000000;
    localparam logic [DATA_W-1:0]  DATA_RST   = 16'h0000;
    localparam logic [PAGE_W-1:0]  PAGE_RST   = 8'h00;
    localparam logic [LANES-1:0]   LANES_OFF  = 3'h0;

    typedef enum logic [1:0] {
        table_read_low_word,
        table_read_high_byte,
        table_write_low_word,
        table_write_high_byte
    } pmta_op_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_DONE
    } pmta_state_type;

    function automatic logic [CNT_W-1:0] erase_instr(input logic [1:0] sel);
        logic [CNT_W-1:0] n;
        n = ERASE_SMALL;
        case (sel)
            SEL_MID:   n = ERASE_MID;
            SEL_LARGE: n = ERASE_LARGE;
            default:   n = ERASE_SMALL;
        endcase
        return n;
    endfunction

    // base of an aligned block; each instruction spans two addresses
    function automatic logic [PADDR_W-1:0] block_base(
        input logic [PADDR_W-1:0] addr,
        input logic [CNT_W-1:0]   instr);
        logic [PADDR_W-1:0] span;
        span = PADDR_W'(instr) << ADDR_SHIFT;
        return addr & ~(span - PADDR_W'(1));
    endfunction

endpackage
`default_nettype wire

// file: verilog/pmta_lane_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pmta_lane_if;
    import pmta_pkg::*;
    pmta_op_type        op;
    logic               byte_mode;
    logic               odd_byte;
    logic [PWORD_W-1:0] mem_word;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata;
    logic [PWORD_W-1:0] wword;
    logic [LANES-1:0]   lane_en;

    modport ctrl (output op, byte_mode, odd_byte, mem_word, wdata,
                  input  rdata, wword, lane_en);
    modport fmt  (input  op, byte_mode, odd_byte, mem_word, wdata,
                  output rdata, wword, lane_en);
endinterface
`default_nettype wire

// file: verilog/pmta_lane.sv
`timescale 1ns/10ps
`default_nettype none
module pmta_lane
    import pmta_pkg::*;
(
    pmta_lane_if.fmt lane
);

    logic [BYTE_W-1:0] sel_byte;

    always_comb begin
        lane.rdata   = DATA_RST;
        lane.wword   = WORD_RST;
        lane.lane_en = LANES_OFF;
        sel_byte     = lane.odd_byte ? lane.mem_word[LOW_MSB:BYTE_W]
                                     : lane.mem_word[BYTE_W-1:LOW_LSB];
        case (lane.op)
            table_read_low_word: begin
                if (lane.byte_mode) begin
                    lane.rdata = {{BYTE_W{1'b0}}, sel_byte};
                end else begin
                    lane.rdata = lane.mem_word[LOW_MSB:LOW_LSB];
                end
            end
            table_read_high_byte: begin
                if (!(lane.byte_mode && lane.odd_byte)) begin
                    lane.rdata = {{BYTE_W{1'b0}},
                                  lane.mem_word[HIGH_MSB:HIGH_LSB]};
                end
            end
            table_write_low_word: begin
                if (lane.byte_mode) begin
                    lane.wword = {{BYTE_W{1'b0}},
                                  lane.wdata[BYTE_W-1:LOW_LSB],
                                  lane.wdata[BYTE_W-1:LOW_LSB]};
                    lane.lane_en[lane.odd_byte] = 1'b1;
                end else begin
                    lane.wword = {{BYTE_W{1'b0}}, lane.wdata};
                    lane.lane_en[1:0] = 2'h3;
                end
            end
            table_write_high_byte: begin
                lane.wword = {lane.wdata[BYTE_W-1:LOW_LSB],
                              {DATA_W{1'b0}}};
                if (!(lane.byte_mode && lane.odd_byte)) begin
                    lane.lane_en[LANE_HIGH] = 1'b1;
                end
            end
            default: begin
                lane.rdata = DATA_RST;
            end
        endcase
    end

endmodule
`default_nettype wire

// file: verilog/pmta_top.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - program address is formed from page register and effective address
// - low-word read and write move program bits 15 to 0
// - low-word accesses work in word mode or single byte mode
// - high accesses move program bits 23 to 16, in word mode or in byte mode at an even address only
// - self-programming writes whole rows of 32 instructions, 96 bytes
// - erase block is 32, 64 or 128 instructions, chosen by select field
// - table accesses allowed from data side in normal operating mode
module pmta_top
    import pmta_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               normal_mode,
    input  wire logic               page_wr,
    input  wire logic [PAGE_W-1:0]  page_wdata,
    output logic [PAGE_W-1:0]       program_page_register,
    input  wire logic               tbl_req,
    input  wire pmta_op_type        tbl_op,
    input  wire logic               tbl_byte,
    input  wire logic [EA_W-1:0]    tbl_ea,
    input  wire logic [DATA_W-1:0]  tbl_wdata,
    output logic                    tbl_ready,
    output logic                    tbl_done,
    output logic [DATA_W-1:0]       tbl_rdata,
    input  wire logic [1:0]         erase_operation_select,
    output logic [CNT_W-1:0]        erase_block_instr,
    output logic [PADDR_W-1:0]      erase_block_base,
    output logic [CNT_W-1:0]        row_block_instr,
    output logic [PADDR_W-1:0]      row_block_base,
    output logic                    mem_rd,
    output logic                    mem_wr,
    output logic [PADDR_W-1:0]      mem_addr,
    output logic [PWORD_W-1:0]      mem_wdata,
    output logic [LANES-1:0]        mem_lane_en,
    input  wire logic [PWORD_W-1:0] mem_rdata
);

    pmta_lane_if lane ();

    pmta_state_type     state_r;
    pmta_state_type     state_nxt;
    pmta_op_type        op_r;
    logic               byte_r;
    logic               odd_r;
    logic [DATA_W-1:0]  wdata_r;
    logic [PAGE_W-1:0]  page_r;
    logic [PADDR_W-1:0] addr_nxt;
    logic               accept;

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    function automatic logic op_is_read(input pmta_op_type op);
        return (op == table_read_low_word) ||
               (op == table_read_high_byte);
    endfunction

    function automatic logic op_is_write(input pmta_op_type op);
        return (op == table_write_low_word) ||
               (op == table_write_high_byte);
    endfunction

    // ------------------------------------------------------------
    // request acceptance
    // ------------------------------------------------------------
    // normal mode gate
    assign tbl_ready = (state_r == ST_IDLE) && normal_mode;
    assign accept    = tbl_req && tbl_ready;
    assign program_page_register = page_r;

    assign addr_nxt = {page_r, tbl_ea[EA_W-1:1], 1'b0};

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:   state_nxt = accept ? ST_ACCESS : ST_IDLE;
            ST_ACCESS: state_nxt = ST_DONE;
            ST_DONE:   state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // page register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            page_r <= PAGE_RST;
        end else if (page_wr) begin
            page_r <= page_wdata;
        end
    end

    // ------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_r    <= table_read_low_word;
            byte_r  <= 1'b0;
            odd_r   <= 1'b0;
            wdata_r <= DATA_RST;
        end else if (accept) begin
            op_r    <= tbl_op;
            byte_r  <= tbl_byte;
            odd_r   <= tbl_ea[0];
            wdata_r <= tbl_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_addr <= WORD_RST;
        end else if (accept) begin
            mem_addr <= addr_nxt;
        end
    end

    // ------------------------------------------------------------
    // lane formatting
    // ------------------------------------------------------------
    assign lane.op        = op_r;
    assign lane.byte_mode = byte_r;
    assign lane.odd_byte  = odd_r;
    assign lane.mem_word  = mem_rdata;
    assign lane.wdata     = wdata_r;

    pmta_lane u_lane (
        .lane (lane.fmt)
    );

    // ------------------------------------------------------------
    // memory strobes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_rd <= 1'b0;
        end else begin
            mem_rd <= accept && op_is_read(tbl_op);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_wr <= 1'b0;
        end else begin
            mem_wr <= (state_r == ST_ACCESS) && op_is_write(op_r);
        end
    end

    // ------------------------------------------------------------
    // write data and lanes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_wdata   <= WORD_RST;
            mem_lane_en <= LANES_OFF;
        end else begin
            mem_wdata   <= lane.wword;
            mem_lane_en <= (state_r == ST_ACCESS) ? lane.lane_en
                                                  : LANES_OFF;
        end
    end

    // ------------------------------------------------------------
    // answer to the core
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tbl_done <= 1'b0;
        end else begin
            tbl_done <= (state_r == ST_ACCESS);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tbl_rdata <= DATA_RST;
        end else if (state_r == ST_ACCESS) begin
            tbl_rdata <= lane.rdata;
        end
    end

    // ------------------------------------------------------------
    // self-programming row geometry
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            row_block_instr <= ROW_INSTR;
            row_block_base  <= WORD_RST;
        end else begin
            row_block_instr <= ROW_INSTR;
            row_block_base  <= block_base(mem_addr, ROW_INSTR);
        end
    end

    // ------------------------------------------------------------
    // erase block geometry
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            erase_block_instr <= ERASE_SMALL;
            erase_block_base  <= WORD_RST;
        end else begin
            erase_block_instr <= erase_instr(erase_operation_select);
            erase_block_base  <= block_base(mem_addr,
                                     erase_instr(erase_operation_select));
        end
    end

endmodule
`default_nettype wire

// file: tb/pmta_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pmta_chk
    import pmta_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic               normal_mode,
    input wire logic               tbl_req,
    input wire pmta_op_type        tbl_op,
    input wire logic [EA_W-1:0]    tbl_ea,
    input wire logic [PAGE_W-1:0]  program_page_register,
    input wire logic               tbl_ready,
    input wire logic               tbl_done,
    input wire logic [1:0]         erase_operation_select,
    input wire logic [CNT_W-1:0]   erase_block_instr,
    input wire logic [CNT_W-1:0]   row_block_instr,
    input wire logic               mem_rd,
    input wire logic               mem_wr,
    input wire logic [PADDR_W-1:0] mem_addr,
    input wire logic [LANES-1:0]   mem_lane_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic acc;
    assign acc = tbl_req && tbl_ready;
    // ----------------
    // checks
    // ----------------
    property p_done; acc |=> !tbl_done ##1 tbl_done; endproperty
    a_done: assert property (p_done) else $error("done late");
    property p_busy; acc |=> !tbl_ready [*2]; endproperty
    a_busy: assert property (p_busy) else $error("busy lost");
    property p_mode; !normal_mode |-> !tbl_ready; endproperty
    a_mode: assert property (p_mode) else $error("ready off mode");
    property p_addr; acc |=> mem_addr == {$past(program_page_register),
        $past(tbl_ea[15:1]), 1'b0}; endproperty
    a_addr: assert property (p_addr) else $error("bad addr");
    property p_rd; acc && tbl_op inside {table_read_low_word,
        table_read_high_byte} |=> mem_rd ##1 !mem_rd; endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_wr; acc && tbl_op inside {table_write_low_word,
        table_write_high_byte} |=> !mem_wr ##1 mem_wr; endproperty
    a_wr: assert property (p_wr) else $error("bad write");
    property p_lane; !mem_wr |-> mem_lane_en == LANES_OFF; endproperty
    a_lane: assert property (p_lane) else $error("stray lane");
    property p_row; row_block_instr == 8'h20; endproperty
    a_row: assert property (p_row) else $error("bad row");
    property p_erase; !$past(rst) |-> erase_block_instr ==
        ($past(erase_operation_select) == 2'h1 ? 8'h40 :
        $past(erase_operation_select) == 2'h2 ? 8'h80 : 8'h20); endproperty
    a_erase: assert property (p_erase) else $error("bad erase");
endmodule
bind pmta_top pmta_chk pmta_chk_i (.*);
`default_nettype wire

// file: tb/pmta_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmta_mem_model
    import pmta_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               mem_rd,
    input wire logic               mem_wr,
    input wire logic [PADDR_W-1:0] mem_addr,
    input wire logic [PWORD_W-1:0] mem_wdata,
    input wire logic [LANES-1:0]   mem_lane_en,
    output logic [PWORD_W-1:0]     mem_rdata
);
    logic [PWORD_W-1:0] mem [16];
    initial begin
        foreach (mem[i]) mem[i] = WORD_RST;
    end
    // word shown while mem_rd is high, inverse word otherwise
    assign mem_rdata = mem_rd ? mem[mem_addr[4:1]] : ~mem[mem_addr[4:1]];
    always @(posedge sys_clk) begin
        for (int l = 0; l < LANES; l++)
            if (mem_wr && mem_lane_en[l])
                mem[mem_addr[4:1]][l*8 +: 8] <= mem_wdata[l*8 +: 8];
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pmta_pkg::*;
    logic               sys_clk, rst, normal_mode, page_wr, tbl_req;
    logic               tbl_byte, tbl_ready, tbl_done, mem_rd, mem_wr;
    pmta_op_type        tbl_op;
    logic [PAGE_W-1:0]  page_wdata, program_page_register, page;
    logic [EA_W-1:0]    tbl_ea;
    logic [DATA_W-1:0]  tbl_wdata, tbl_rdata, got;
    logic [1:0]         erase_operation_select;
    logic [CNT_W-1:0]   erase_block_instr, row_block_instr;
    logic [PADDR_W-1:0] erase_block_base, row_block_base, mem_addr;
    logic [PWORD_W-1:0] mem_wdata, mem_rdata;
    logic [LANES-1:0]   mem_lane_en;
    int                 n_mismatch, comparisons;
    pmta_top       pmta_top_i (.*);
    pmta_mem_model pmta_mem_model_i (.*);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ----------------
    // helpers
    // ----------------
    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string what, logic [23:0] exp, logic [23:0] act);
        comparisons++;
        if (act !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        while (s !== 1'b1) begin
            tick();
            k++;
            if (k > 8) begin
                chk("handshake", 24'h1, 24'h0);
                final_report();
            end
        end
    endtask
    task automatic set_page(logic [7:0] p);
        page_wdata = p;
        page_wr = 1'b1;
        tick();
        page_wr = 1'b0;
        page = p;
        chk("page", 24'(p), 24'(program_page_register));
    endtask
    task automatic acc(pmta_op_type op, logic b, logic [15:0] ea,
                       logic [15:0] wd);
        wait_hi(tbl_ready);
        tbl_op = op;
        tbl_byte = b;
        tbl_ea = ea;
        tbl_wdata = wd;
        tbl_req = 1'b1;
        tick();
        tbl_req = 1'b0;
        chk("mem_addr", {page, ea[15:1], 1'b0}, mem_addr);
        wait_hi(tbl_done);
        got = tbl_rdata;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        chk("row_instr", 24'h20, 24'(row_block_instr));
        chk("erase_instr", 24'h20, 24'(erase_block_instr));
    endtask
    task automatic t_rw();
        set_page(8'h5A);
        acc(table_write_low_word, 1'b0, 16'h0010, 16'hBEEF);
        acc(table_write_high_byte, 1'b0, 16'h0010, 16'h00C3);
        acc(table_read_low_word, 1'b0, 16'h0010, 16'h0000);
        chk("rd_low", 24'hBEEF, 24'(got));
        acc(table_read_high_byte, 1'b0, 16'h0010, 16'h0000);
        chk("rd_high", 24'hC3, 24'(got));
        acc(table_read_high_byte, 1'b1, 16'h0010, 16'h0000);
        chk("rd_high_b", 24'hC3, 24'(got));
        acc(table_write_high_byte, 1'b1, 16'h0011, 16'h0055);
        acc(table_read_high_byte, 1'b1, 16'h0011, 16'h0000);
        chk("rd_high_odd", 24'h0, 24'(got));
        acc(table_read_high_byte, 1'b0, 16'h0010, 16'h0000);
        chk("rd_high_keep", 24'hC3, 24'(got));
        acc(table_read_low_word, 1'b1, 16'h0010, 16'h0000);
        chk("rd_b0", 24'hEF, 24'(got));
        acc(table_read_low_word, 1'b1, 16'h0011, 16'h0000);
        chk("rd_b1", 24'hBE, 24'(got));
        acc(table_write_low_word, 1'b1, 16'h0011, 16'h0077);
        set_page(8'hA5);
        acc(table_read_low_word, 1'b0, 16'h0010, 16'h0000);
        chk("rd_wb", 24'h77EF, 24'(got));
    endtask
    task automatic t_mode();
        normal_mode = 1'b0;
        tbl_req = 1'b1;
        repeat (4) begin
            tick();
            chk("idle", 24'h0, {tbl_done, mem_rd, mem_wr});
            chk("ready", 24'h0, 24'(tbl_ready));
        end
        tbl_req = 1'b0;
        normal_mode = 1'b1;
    endtask
    task automatic t_geom();
        logic [7:0]  n [4] = '{8'h20, 8'h40, 8'h80, 8'h20};
        logic [23:0] b [4] = '{24'hA50040, 24'hA50000, 24'hA50000,
                               24'hA50040};
        acc(table_read_low_word, 1'b0, 16'h0052, 16'h0000);
        chk("row_base", 24'hA50040, row_block_base);
        for (int s = 0; s < 4; s++) begin
            erase_operation_select = 2'(s);
            tick();
            chk("erase_instr", 24'(n[s]), 24'(erase_block_instr));
            chk("erase_base", b[s], erase_block_base);
        end
    endtask
    initial begin
        rst = 1'b1;
        normal_mode = 1'b1;
        page_wr = 1'b0;
        page_wdata = 8'h00;
        page = 8'h00;
        tbl_req = 1'b0;
        tbl_op = table_read_low_word;
        tbl_byte = 1'b0;
        tbl_ea = 16'h0000;
        tbl_wdata = 16'h0000;
        erase_operation_select = 2'h0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_rw();
        t_mode();
        t_geom();
        final_report();
    end
endmodule
`default_nettype wire
